// ===== logic/mt8_pkg.sv
// shared constants and types of the modulo timer
`default_nettype none

package mt8_pkg;

	// ---------------------------------------------------------------
	// register map, byte offsets within the slave window
	// ---------------------------------------------------------------
	localparam int REG_ADDR_W = 8;
	localparam logic [7:0] OFS_STATUS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CLOCK_CFG = 8'h04;
	localparam logic [7:0] OFS_COUNT = 8'h08;
	localparam logic [7:0] OFS_WRAP_LIMIT = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int SC_FLAG_BIT = 7;
	localparam int SC_IRQEN_BIT = 6;
	localparam int SC_CLEAR_BIT = 5;
	localparam int SC_HALT_BIT = 4;
	localparam int CFG_SRC_HI = 5;
	localparam int CFG_SRC_LO = 4;
	localparam int CFG_PS_HI = 3;
	localparam int CFG_PS_LO = 0;
	localparam int IRQ_OVF_BIT = 0;
	localparam int HTRANS_ACTIVE_BIT = 1;

	// ---------------------------------------------------------------
	// reset values and limits
	// ---------------------------------------------------------------
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] LIMIT_RST = 8'h00;
	localparam logic [7:0] FREE_RUN_TOP = 8'hFF;
	localparam logic [3:0] PS_RST = 4'h0;
	localparam logic [3:0] PS_MAX = 4'h8;
	localparam logic [7:0] PRE_RST = 8'h00;
	localparam logic HALT_RST = 1'b1;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	// ---------------------------------------------------------------
	// clock source encodings and bus states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_BUS = 2'h0,
		SRC_FIXED = 2'h1,
		SRC_EXT_FALL = 2'h2,
		SRC_EXT_RISE = 2'h3
	} mt8_src_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WRITE,
		ST_RDCAP,
		ST_RDOUT
	} mt8_bus_st_t;

endpackage

`default_nettype wire

// ===== logic/mt8_src.sv
// clock source selection, pin synchronisers and prescaler
`timescale 1ns/10ps
`default_nettype none

module mt8_src (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic run,
	input wire logic [1:0] src_sel,
	input wire logic [3:0] ps_sel,
	// asynchronous count sources
	input wire logic fixed_in,
	input wire logic ext_in,
	// prescaled count enable
	output logic tick
);
	import mt8_pkg::*;

	// ---------------------------------------------------------------
	// prescaler mask: codes above eight act as eight
	// ---------------------------------------------------------------
	function automatic logic [7:0] ps_mask(input logic [3:0] ps);
		if (ps >= PS_MAX) begin
			return FREE_RUN_TOP;
		end
		return (8'h01 << ps[2:0]) - 8'h01;
	endfunction

	logic [1:0] pin_in;
	logic [2:0] sync_q [0:1];
	logic lvl_q [0:1];
	logic agree [0:1];
	logic rise [0:1];
	logic fall [0:1];
	logic sel_pulse;
	logic src_pulse;
	logic [7:0] pre_q;
	logic [7:0] mask;

	assign pin_in = {ext_in, fixed_in};

	// three-stage synchronisers, a level counts once stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2; i++) begin
				sync_q[i] <= 3'h0;
				lvl_q[i] <= 1'b0;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				sync_q[i] <= {sync_q[i][1:0], pin_in[i]};
				if (agree[i]) begin
					lvl_q[i] <= sync_q[i][2];
				end
			end
		end
	end

	// settled level and edges of each pin
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_pin
			assign agree[g] = sync_q[g][1] == sync_q[g][2]; // R17
			assign rise[g] = agree[g] && sync_q[g][2] && !lvl_q[g];
			assign fall[g] = agree[g] && !sync_q[g][2] && lvl_q[g];
		end
	endgenerate

	// source selection, gated by run
	assign sel_pulse = (src_sel == SRC_BUS) ? 1'b1 :
		(src_sel == SRC_FIXED) ? rise[0] :
		(src_sel == SRC_EXT_FALL) ? fall[1] : rise[1]; // R08
	assign src_pulse = run && sel_pulse;
	assign mask = ps_mask(ps_sel); // R10 R11
	assign tick = src_pulse && ((pre_q & mask) == mask); // R18

	// free-running prescaler, never cleared by a setting change
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= PRE_RST;
		end else if (src_pulse) begin
			pre_q <= pre_q + 8'h01; // R12
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	prescale_cap_a: assert property ( // R11
		(ps_sel >= PS_MAX) && tick |-> pre_q == FREE_RUN_TOP)
		else $error("prescale above eight not treated as 256");
	ext_edge_sync_a: assert property ( // R17
		run && (src_sel == SRC_EXT_RISE) && tick |->
		$past(sync_q[1][2]) == 1'b0 && sync_q[1][2])
		else $error("external edge counted without settled sync");
endmodule

`default_nettype wire

// ===== logic/mt8_top.sv
// modulo timer top: AHB-Lite register slave, counter, flag and interrupt
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// R01: overflow flag bit 7 sets when counter rolls from wrap limit to zero.
// R02: flag clears by reading status while set, then writing zero to it.
// R03: counter clear write or any wrap limit write also clears the flag.
// R04: interrupt asserts while interrupt enable bit 6 and flag are both set.
// R05: software clears the flag before it sets the interrupt enable.
// R06: writing one to clear bit 5 zeroes counter and flag; reads zero.
// R07: halt bit 4 freezes the count; reset sets it; clearing resumes.
// R08: source field 5:4 picks bus, fixed, pin falling or pin rising.
// R09: changing the source keeps the count and continues on the new source.
// R10: prescale field 3:0 divides by two to the code, up to 256.
// R11: prescale codes above eight divide by 256.
// R12: changing prescale keeps the count; reset clears the field.
// R13: count register reads the counter, ignores writes, resets to zero.
// R14: counter rolls at wrap limit; zero limit gives free 8-bit counting.
// R15: any wrap limit write zeroes the counter and clears the flag.
// R16: an overflow between flag read and clearing write keeps the flag.
// R17: external input is synchronised; it toggles at most quarter bus rate.
// R18: one bus-clock count enable drives all counter and flag updates.
module mt8_top (
	// clock and reset
	input wire logic MCLK,
	input wire logic RSTN,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic [1:0] HRESP,
	// count source pins
	input wire logic FIXED_RATE_CLOCK,
	input wire logic EXTERNAL_COUNT_INPUT,
	// interrupt
	output logic IRQ
);
	import mt8_pkg::*;

	// ---------------------------------------------------------------
	// wrap detection
	// ---------------------------------------------------------------
	function automatic logic wrap_hit(input logic [7:0] cnt,
		input logic [7:0] lim);
		return cnt == ((lim == LIMIT_RST) ? FREE_RUN_TOP : lim);
	endfunction

	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic [1:0] rst_s_q;
	logic rst_n;

	// two-stage release of the asynchronous reset
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_s_q <= 2'h0;
		end else begin
			rst_s_q <= {rst_s_q[0], 1'b1};
		end
	end
	assign rst_n = rst_s_q[1];

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	mt8_bus_st_t st_q, st_d;
	logic [7:0] addr_q;
	logic [31:0] hrdata_q;
	logic accept;
	logic [7:0] wdat;
	logic wr_go, wr_sc, wr_cfg, wr_lim, wr_ist, wr_msk;
	logic rd_cap, rd_sc;
	logic [7:0] sc_rd, cfg_rd, rd_mux;

	// address phase taken when selected, active and bus ready
	assign accept = HSEL && HTRANS[HTRANS_ACTIVE_BIT] && HREADY;

	// state advance: writes land in data phase, reads take one wait
	// the wait lets read data come straight from a flop
	always_comb begin
		st_d = ST_IDLE;
		case (st_q)
			ST_RDCAP: begin
				st_d = ST_RDOUT;
			end
			ST_IDLE, ST_WRITE, ST_RDOUT: begin
				if (accept) begin
					st_d = HWRITE ? ST_WRITE : ST_RDCAP;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	// bus state, address and read data registers
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= ST_IDLE;
			addr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end else begin
			st_q <= st_d;
			if (accept) begin
				addr_q <= HADDR[REG_ADDR_W-1:0];
			end
			if (rd_cap) begin
				hrdata_q <= {24'h00_0000, rd_mux};
			end
		end
	end

	assign HREADYOUT = st_q != ST_RDCAP;
	assign HRESP = HRESP_OKAY;
	assign HRDATA = hrdata_q;

	// write strobes and data byte
	assign wdat = HWDATA[7:0];
	assign wr_go = st_q == ST_WRITE;
	assign wr_sc = wr_go && (addr_q == OFS_STATUS_CTRL);
	assign wr_cfg = wr_go && (addr_q == OFS_CLOCK_CFG);
	assign wr_lim = wr_go && (addr_q == OFS_WRAP_LIMIT);
	assign wr_ist = wr_go && (addr_q == OFS_IRQ_STATUS);
	assign wr_msk = wr_go && (addr_q == OFS_IRQ_MASK);
	assign rd_cap = st_q == ST_RDCAP;
	assign rd_sc = rd_cap && (addr_q == OFS_STATUS_CTRL);

	// ---------------------------------------------------------------
	// timer registers
	// ---------------------------------------------------------------
	logic tof_q, tof_d;
	logic armed_q, armed_d;
	logic overflow_irq_enable_q, halt_q;
	logic [1:0] src_q;
	logic [3:0] ps_q;
	logic [7:0] limit_q;
	logic [7:0] cnt_q, cnt_d;
	logic ist_q, ist_d, msk_q;
	logic tick, ovf, cnt_clear, flag_clr;

	// read view; clear bit always reads zero, unmapped reads zero
	assign sc_rd = {tof_q, overflow_irq_enable_q, 1'b0, halt_q, 4'h0}; // R06
	assign cfg_rd = {2'h0, src_q, ps_q};
	assign rd_mux = (addr_q == OFS_STATUS_CTRL) ? sc_rd :
		(addr_q == OFS_CLOCK_CFG) ? cfg_rd :
		(addr_q == OFS_COUNT) ? cnt_q : // R13
		(addr_q == OFS_WRAP_LIMIT) ? limit_q :
		(addr_q == OFS_IRQ_STATUS) ? {7'h00, ist_q} :
		(addr_q == OFS_IRQ_MASK) ? {7'h00, msk_q} : 8'h00;

	// prescaled count enable
	mt8_src i_mt8_src (
		.clk(MCLK),
		.rst_n(rst_n),
		.run(!halt_q), // R07
		.src_sel(src_q),
		.ps_sel(ps_q),
		.fixed_in(FIXED_RATE_CLOCK),
		.ext_in(EXTERNAL_COUNT_INPUT),
		.tick(tick)
	);

	// counter next value and overflow event
	// clears win over a step, so a cleared count never shows a late step
	assign ovf = tick && wrap_hit(cnt_q, limit_q); // R01 R14
	assign cnt_clear = (wr_sc && wdat[SC_CLEAR_BIT]) || wr_lim; // R06 R15
	assign cnt_d = cnt_clear ? COUNT_RST :
		ovf ? COUNT_RST :
		tick ? cnt_q + 8'h01 : cnt_q; // R14 R18

	// flag clearing: armed read then zero write, or clear/limit write
	assign flag_clr = cnt_clear ||
		(wr_sc && !wdat[SC_FLAG_BIT] && armed_q); // R02 R03
	assign tof_d = ovf ? 1'b1 : (flag_clr ? 1'b0 : tof_q); // R16
	assign armed_d = (ovf || flag_clr) ? 1'b0 :
		((rd_sc && tof_q) ? 1'b1 : armed_q); // R16
	assign ist_d = ovf ? 1'b1 :
		((wr_ist && wdat[IRQ_OVF_BIT]) ? 1'b0 : ist_q);

	// counter and flags
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= COUNT_RST;
			tof_q <= 1'b0;
			armed_q <= 1'b0;
			ist_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tof_q <= tof_d;
			armed_q <= armed_d;
			ist_q <= ist_d;
		end
	end

	// software-written control
	always_ff @(posedge MCLK or negedge rst_n) begin
		if (!rst_n) begin
			overflow_irq_enable_q <= 1'b0;
			halt_q <= HALT_RST;
			src_q <= SRC_BUS;
			ps_q <= PS_RST;
			limit_q <= LIMIT_RST;
			msk_q <= 1'b0;
		end else begin
			if (wr_sc) begin
				overflow_irq_enable_q <= wdat[SC_IRQEN_BIT];
				halt_q <= wdat[SC_HALT_BIT]; // R07
			end
			if (wr_cfg) begin
				src_q <= wdat[CFG_SRC_HI:CFG_SRC_LO]; // R08 R09
				ps_q <= wdat[CFG_PS_HI:CFG_PS_LO]; // R12
			end
			if (wr_lim) begin
				limit_q <= wdat;
			end
			if (wr_msk) begin
				msk_q <= wdat[IRQ_OVF_BIT];
			end
		end
	end

	// interrupt level
	// an old flag fires at once if the enable is set before clearing it
	assign IRQ = (tof_q && overflow_irq_enable_q) || (ist_q && msk_q); // R04

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!rst_n);

	// flag, clearing and interrupt
	ovf_sets_flag_a: assert property ( // R01
		ovf |=> tof_q && ist_q)
		else $error("overflow did not set flag");
	read_arms_a: assert property ( // R02
		rd_sc && tof_q && !ovf |=> armed_q)
		else $error("flag read did not arm the clearing write");
	flag_clear_seq_a: assert property ( // R02
		armed_q && wr_sc && !wdat[SC_FLAG_BIT] && !ovf |=> !tof_q)
		else $error("read then zero write did not clear flag");
	zero_write_unarmed_a: assert property ( // R02
		wr_sc && !wdat[SC_FLAG_BIT] && !wdat[SC_CLEAR_BIT] && !armed_q
		&& tof_q |=> tof_q)
		else $error("flag cleared without prior read");
	clear_write_a: assert property ( // R03
		(wr_sc && wdat[SC_CLEAR_BIT]) && !ovf |=> !tof_q && cnt_q == 8'h00)
		else $error("counter clear write failed");
	irq_follows_a: assert property ( // R04
		ovf && overflow_irq_enable_q && !wr_sc |=> IRQ)
		else $error("enabled overflow raised no interrupt");
	irq_quiet_a: assert property ( // R04
		!tof_q && !ist_q |-> !IRQ)
		else $error("interrupt without a set status bit");
	// counter
	halt_holds_a: assert property ( // R07
		halt_q && !wr_sc && !wr_lim |=> $stable(cnt_q))
		else $error("counter moved while halted");
	cfg_keeps_count_a: assert property ( // R09
		wr_cfg && !tick |=> cnt_q == $past(cnt_q))
		else $error("configuration write disturbed count");
	count_ro_a: assert property ( // R13
		wr_go && addr_q == OFS_COUNT && !tick |=> $stable(cnt_q))
		else $error("count register accepted a write");
	wrap_roll_a: assert property ( // R14
		ovf && !cnt_clear |=> cnt_q == 8'h00)
		else $error("counter did not roll to zero");
	limit_write_a: assert property ( // R15
		wr_lim && !ovf |=> cnt_q == 8'h00 && !tof_q)
		else $error("limit write did not reset counter");
	late_ovf_keeps_a: assert property ( // R16
		ovf && wr_sc && !wdat[SC_FLAG_BIT] |=> tof_q)
		else $error("new overflow lost during clearing");
	step_one_a: assert property ( // R18
		tick && !ovf && !cnt_clear |=> cnt_q == $past(cnt_q) + 8'h01)
		else $error("count enable did not step by one");

	// bus read view and clearing race
	count_read_a: assert property ( // R13
		rd_cap && addr_q == OFS_COUNT |=>
		HRDATA == {24'h00_0000, $past(cnt_q)})
		else $error("count read did not show the counter");
	race_disarm_a: assert property ( // R16
		ovf |=> !armed_q)
		else $error("overflow left the clearing sequence armed");

	// main scenarios
	cov_overflow_c: cover property (ovf ##1 IRQ);
	cov_clear_seq_c: cover property (rd_sc && tof_q ##[1:4] flag_clr);
	cov_limit_wrap_c: cover property (ovf && limit_q != LIMIT_RST);
	cov_ext_source_c: cover property (tick && src_q == SRC_EXT_FALL);
	cov_race_c: cover property (armed_q && ovf);
endmodule

`default_nettype wire

// ===== testbench/tb_mt8_top.sv
// self-checking bench of the modulo timer through its register bus
`timescale 1ns/10ps
`default_nettype none

module tb_mt8_top;
	import mt8_pkg::*;

	logic mclk, rstn, hsel, hwrite, fix, ext;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, r, v;
	wire logic [31:0] hrdata;
	wire logic hready, irq;
	wire logic [1:0] hresp;
	int failures, checked;

	mt8_top i_mt8_top (.MCLK(mclk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
		.HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
		.FIXED_RATE_CLOCK(fix), .EXTERNAL_COUNT_INPUT(ext), .IRQ(irq));

	// 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// ---------------------------------------------------------------
	// bus, pin and judging helpers
	// ---------------------------------------------------------------
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	// bounded wait for hready sampled high at a rising edge
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (hready !== 1'b1) begin
			failures++;
			finish_test();
		end
	endtask

	// one single word transfer, read data left in r
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wait_ready();
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_ready();
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 8'h00);
	endtask

	// full pulses on one pin, toggling at a quarter of the bus rate
	task automatic pulse(input logic on_ext, input int n);
		repeat (n) begin
			ext <= on_ext;
			fix <= !on_ext;
			repeat (4) @(posedge mclk);
			ext <= 1'b0;
			fix <= 1'b0;
			repeat (4) @(posedge mclk);
		end
		repeat (8) @(posedge mclk);
	endtask

	// poll the count until it shows a value, bounded
	task automatic poll(input logic [7:0] val);
		int n;
		n = 0;
		do begin
			rd(OFS_COUNT);
			n++;
		end while (r[7:0] !== val && n < 60);
		if (r[7:0] !== val) begin
			failures++;
			finish_test();
		end
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		rd(OFS_STATUS_CTRL);
		check("status", r, 32'h10);
		rd(OFS_CLOCK_CFG);
		check("clkcfg", r, 32'h0);
		wr(OFS_COUNT, 8'h55);
		rd(OFS_COUNT);
		check("count", r, 32'h0);
		rd(OFS_WRAP_LIMIT);
		check("limit", r, 32'h0);
		wr(8'h18, 8'hFF);
		rd(8'h18);
		check("unmapped", r, 32'h0);
		check("hresp", {30'h0, hresp}, 32'h0);
		$display("test reset done");
	endtask

	// prescale codes 0, 1, 2, 3, 5, 8, 9 and 15 over a fixed run, then the hold on halt
	task automatic t_prescale();
		logic [3:0] codes[8];
		int c;
		codes = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h8, 4'h9, 4'hF};
		for (int i = 0; i < 8; i++) begin
			wr(OFS_STATUS_CTRL, 8'h30);
			wr(OFS_CLOCK_CFG, {4'h0, codes[i]});
			wr(OFS_STATUS_CTRL, 8'h00);
			repeat (192) @(posedge mclk);
			wr(OFS_STATUS_CTRL, 8'h10);
			rd(OFS_COUNT);
			c = (codes[i] > 4'h8) ? 8 : int'(codes[i]);
			v = r;
			check("rate", {31'h0, r >= (192 >> c) && r <= (200 >> c) + 1},
				32'h1);
			repeat (20) @(posedge mclk);
			rd(OFS_COUNT);
			check("held", r, v);
		end
		$display("test prescale done");
	endtask

	// source selection and setting changes while running
	task automatic t_source();
		wr(OFS_STATUS_CTRL, 8'h30);
		wr(OFS_CLOCK_CFG, 8'h10);
		wr(OFS_STATUS_CTRL, 8'h00);
		pulse(1'b0, 6);
		rd(OFS_COUNT);
		check("fixed", r, 32'h6);
		wr(OFS_CLOCK_CFG, 8'h20);
		pulse(1'b0, 3);
		rd(OFS_COUNT);
		check("srcchg", r, 32'h6);
		pulse(1'b1, 5);
		rd(OFS_COUNT);
		check("fall", r, 32'hB);
		wr(OFS_CLOCK_CFG, 8'h30);
		pulse(1'b1, 4);
		rd(OFS_COUNT);
		check("rise", r, 32'hF);
		wr(OFS_CLOCK_CFG, 8'h31);
		rd(OFS_COUNT);
		check("pschg", r, 32'hF);
		pulse(1'b1, 4);
		rd(OFS_COUNT);
		check("div2", {31'h0, r >= 32'h11 && r <= 32'h12}, 32'h1);
		wr(OFS_STATUS_CTRL, 8'h10);
		$display("test source done");
	endtask

	// wrap, flag clearing, interrupt paths and clear bit
	task automatic t_overflow();
		int n;
		wr(OFS_STATUS_CTRL, 8'h30);
		wr(OFS_CLOCK_CFG, 8'h00);
		wr(OFS_WRAP_LIMIT, 8'h03);
		wr(OFS_STATUS_CTRL, 8'h00);
		repeat (40) @(posedge mclk);
		wr(OFS_STATUS_CTRL, 8'h10);
		rd(OFS_COUNT);
		check("wrap", {31'h0, r <= 32'h3}, 32'h1);
		check("irq off", {31'h0, irq}, 32'h0);
		rd(OFS_STATUS_CTRL);
		check("flag", r, 32'h90);
		wr(OFS_STATUS_CTRL, 8'h10);
		rd(OFS_STATUS_CTRL);
		check("flag clr", r, 32'h10);
		wr(OFS_STATUS_CTRL, 8'h00);
		repeat (20) @(posedge mclk);
		wr(OFS_STATUS_CTRL, 8'h10);
		wr(OFS_STATUS_CTRL, 8'h10);
		rd(OFS_STATUS_CTRL);
		check("no arm", r, 32'h90);
		rd(OFS_IRQ_STATUS);
		check("irqst", r, 32'h1);
		wr(OFS_IRQ_MASK, 8'h01);
		@(negedge mclk);
		check("irq mask", {31'h0, irq}, 32'h1);
		wr(OFS_IRQ_STATUS, 8'h01);
		@(negedge mclk);
		check("irq w1c", {31'h0, irq}, 32'h0);
		wr(OFS_IRQ_MASK, 8'h00);
		wr(OFS_STATUS_CTRL, 8'h10);
		wr(OFS_STATUS_CTRL, 8'h50);
		rd(OFS_STATUS_CTRL);
		check("enable", r, 32'h50);
		wr(OFS_STATUS_CTRL, 8'h40);
		n = 0;
		while (irq !== 1'b1 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		check("irq on", {31'h0, irq}, 32'h1);
		if (irq !== 1'b1) begin
			finish_test();
		end
		wr(OFS_STATUS_CTRL, 8'h10);
		wr(OFS_STATUS_CTRL, 8'h30);
		@(negedge mclk);
		check("irq clr", {31'h0, irq}, 32'h0);
		rd(OFS_STATUS_CTRL);
		check("clear bit", r, 32'h10);
		rd(OFS_COUNT);
		check("cleared", r, 32'h0);
		wr(OFS_STATUS_CTRL, 8'h00);
		repeat (20) @(posedge mclk);
		wr(OFS_WRAP_LIMIT, 8'h05);
		wr(OFS_STATUS_CTRL, 8'h10);
		rd(OFS_STATUS_CTRL);
		check("lim flag", r, 32'h10);
		rd(OFS_COUNT);
		check("lim cnt", {31'h0, r <= 32'h4}, 32'h1);
		$display("test overflow done");
	endtask

	// an overflow between the flag read and the zero write keeps the flag
	task automatic t_race();
		wr(OFS_CLOCK_CFG, 8'h05);
		wr(OFS_WRAP_LIMIT, 8'h01);
		wr(OFS_STATUS_CTRL, 8'h00);
		poll(8'h01);
		poll(8'h00);
		poll(8'h01);
		rd(OFS_STATUS_CTRL);
		check("armed", r, 32'h80);
		repeat (40) @(posedge mclk);
		wr(OFS_STATUS_CTRL, 8'h00);
		wr(OFS_STATUS_CTRL, 8'h10);
		rd(OFS_STATUS_CTRL);
		check("race", r, 32'h90);
		$display("test race done");
	endtask

	// reset, then the scenarios in turn
	initial begin
		failures = 0;
		checked = 0;
		rstn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		fix = 1'b0;
		ext = 1'b0;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		t_reset();
		t_prescale();
		t_source();
		t_overflow();
		t_race();
		finish_test();
	end
endmodule

`default_nettype wire
